//--- hdl/multiboot_fallback_reconfig.sv
`timescale 1ns/1ps

// Notes on behaviour
// - watchdog is either configuration monitor or user monitor, never both.
// - timer value from a bitstream also governs later reprogram-started loads.
// - watchdog counts down through the load; zero before start-up triggers fallback.
// - watchdog ticks from a ~65 MHz source, divided, free of user clocks.
// - revision-select pins stay undriven unless a reload or fallback enables them.
// - fallback drives revision-select low in parallel flash or port mode, not serial.
// - fallback restarts from flash address zero with revision-select low.
// - reprogram acts like the program pin but keeps reconfiguration registers.
// - reprogram loads from the warm start address, otherwise from zero.
// - a command word with low four bits all ones means reprogram.
// - reprogram drives init and done low, clears, releases init, then loads.
// - warm start drives revision-select, parallel address or serial start field.
// - serial start field goes out as address bits 31..8, low byte zero.
// - revision-select from warm start except serial; start field in flash modes.
// - reprogram reload outside serial mode actively drives revision-select over any strapping.
// - a failed reprogram-loaded image falls back to the base image.
// - history is a two-entry queue; newest shifts into older, each valid-flagged.
// - fallback image carrying a reprogram command still sets its reprogram flag.
// - after good fallback newest shows fallback+valid; older keeps the error.
// - reprogram commands inside a fallback load are ignored.
// - a failed fallback stops configuration with init and done low.
// - warm start register reads zero unless the bitstream writes it.
module multiboot_fallback_reconfig
  import boot_ctrl_pkg::*;
#(
  parameter int CLEAR_CYCLES = CLEAR_CYC_DEF,
  parameter int TICK_CYCLES  = WDT_TICK_CYC
)
(
  input  logic         ref_clk,
  input  logic         nrst,
  input  logic [1:0]   mode_pins,
  input  logic         icp_valid,
  input  logic [31:0]  icp_data,
  input  logic         flash_valid,
  input  logic [31:0]  flash_data,
  input  load_evt_type load_evt,
  output logic         rd_valid,
  output logic [31:0]  rd_data,
  output logic         load_start,
  output logic [31:0]  load_addr,
  output logic [1:0]   rs_out,
  output logic [1:0]   rs_oe,
  output logic         init_n,
  output logic         done
);

  localparam logic [15:0] CLR_LAST  = 16'(CLEAR_CYCLES - 1);
  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  logic [1:0]     mode_meta_reg, mode_sync_reg;
  cfg_mode_type   mode;
  reg_wr_type     wr;
  logic           rd_req;
  logic [4:0]     rd_addr;
  logic           dec_valid;
  logic [31:0]    dec_data;
  logic           internal_reprogram_cmd;
  logic           wdt_arm, wdt_fire, tick;
  logic           push_c, load_start_c;
  logic [TMR_VAL_W-1:0] tmr_val;
  hist_entry_type ent;

  logic [31:0]    warm_reg,    warm_next;
  logic [31:0]    timer_reg,   timer_next;
  load_state_type state_reg,   state_next;
  attempt_type    kind_reg,    kind_next;
  logic [15:0]    clr_cnt_reg, clr_cnt_next;
  logic [31:0]    start_ws_reg, start_ws_next;
  logic           reprog_reg,  reprog_next;
  logic           wdt_off_reg, wdt_off_next;
  hist_entry_type hist0_reg,   hist0_next;
  hist_entry_type hist1_reg,   hist1_next;
  logic [15:0]    pre_reg,     pre_next;
  logic [TMR_VAL_W-1:0] wdt_reg, wdt_next;
  logic           init_n_reg,  init_n_next;
  logic           done_reg,    done_next;
  logic [1:0]     rs_out_reg,  rs_out_next;
  logic [1:0]     rs_oe_reg,   rs_oe_next;
  logic [31:0]    addr_reg,    addr_next;
  logic           ldst_reg;
  logic           rdv_reg;
  logic [31:0]    rdd_reg,     rdd_next;

  // ==========================================================
  // mode pins come from the board, so synchronise first
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mode_meta_reg <= '0;
      mode_sync_reg <= '0;
    end else begin
      mode_meta_reg <= mode_pins;
      mode_sync_reg <= mode_meta_reg;
    end
  end

  assign mode = cfg_mode_type'(mode_sync_reg);

  // ==========================================================
  // word source: flash during a load, user port once running
  always_comb begin
    dec_valid = 1'b0;
    dec_data  = icp_data;
    if (state_reg == ST_LOAD) begin
      dec_valid = flash_valid;
      dec_data  = flash_data;
    end else if (state_reg == ST_USER) begin
      dec_valid = icp_valid;
    end
  end

  cfg_packet_decoder u_decoder (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .abort      (state_reg == ST_CLEAR || state_reg == ST_HALT),
    .word_valid (dec_valid),
    .word_data  (dec_data),
    .wr         (wr),
    .rd_req     (rd_req),
    .rd_addr    (rd_addr)
  );

  // null code leaves the low bits clear and so does nothing
  assign internal_reprogram_cmd = wr.valid && wr.addr == REG_CMD &&
    wr.data[3:0] == CMD_REPROG_BITS;

  // ==========================================================
  // warm start and timer registers; nrst clears both, each load start clears warm start
  always_comb begin
    warm_next  = warm_reg;
    timer_next = timer_reg;
    if (load_start_c) begin
      warm_next = WARM_START_RST;
    end
    if (wr.valid && wr.addr == REG_WARM_START) begin
      warm_next = wr.data;
    end
    if (wr.valid && wr.addr == REG_TIMER) begin
      timer_next = wr.data;
      // configuration monitoring wins when both are asked for
      if (wr.data[TMR_CFG_MON]) begin
        timer_next[TMR_USR_MON] = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      warm_reg  <= WARM_START_RST;
      timer_reg <= TIMER_RST;
    end else begin
      warm_reg  <= warm_next;
      timer_reg <= timer_next;
    end
  end

  assign tmr_val = timer_reg[TMR_VAL_W-1:0];

  // ==========================================================
  // watchdog: prescaler stands in for the divided internal clock
  assign tick     = (pre_reg == TICK_LAST);
  assign wdt_arm  = state_reg == ST_LOAD && timer_reg[TMR_CFG_MON] &&
                    !wdt_off_reg && kind_reg != ATT_FALLBACK;
  assign wdt_fire = wdt_arm && tick && wdt_reg == '0;

  always_comb begin
    pre_next = tick ? 16'h0000 : pre_reg + 16'h0001;
    wdt_next = wdt_reg;
    if (load_start_c) begin
      wdt_next = tmr_val;
    end else if (state_reg == ST_LOAD && wr.valid &&
                 wr.addr == REG_TIMER) begin
      wdt_next = wr.data[TMR_VAL_W-1:0];
    end else if (wdt_arm && tick && wdt_reg != '0) begin
      wdt_next = wdt_reg - 30'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pre_reg <= '0;
      wdt_reg <= '0;
    end else begin
      pre_reg <= pre_next;
      wdt_reg <= wdt_next;
    end
  end

  // ==========================================================
  // load sequencer and boot history
  always_comb begin
    ent                           = HIST_RST;
    ent.valid                     = 1'b1;
    ent.wrap_err                  = load_evt.wrap_err;
    ent.crc_err                   = load_evt.crc_err;
    ent.device_code_mismatch_flag = load_evt.id_err;
    ent.watchdog_expiry_flag      = wdt_fire;
    ent.fallback                  = (kind_reg == ATT_FALLBACK);
    // recorded even though the command is not obeyed
    ent.reprog = reprog_reg || (internal_reprogram_cmd &&
                                kind_reg == ATT_FALLBACK);
    state_next    = state_reg;
    kind_next     = kind_reg;
    clr_cnt_next  = clr_cnt_reg;
    start_ws_next = start_ws_reg;
    reprog_next   = reprog_reg;
    wdt_off_next  = wdt_off_reg;
    hist0_next    = hist0_reg;
    hist1_next    = hist1_reg;
    push_c        = 1'b0;
    load_start_c  = 1'b0;
    case (state_reg)
      ST_CLEAR: begin
        if (clr_cnt_reg == CLR_LAST) begin
          state_next   = ST_LOAD;
          load_start_c = 1'b1;
        end else begin
          clr_cnt_next = clr_cnt_reg + 16'h0001;
        end
      end
      ST_LOAD: begin
        reprog_next = ent.reprog;
        if (ent.wrap_err || ent.crc_err || ent.watchdog_expiry_flag ||
            ent.device_code_mismatch_flag) begin
          push_c = 1'b1;
          if (kind_reg == ATT_FALLBACK) begin
            state_next = ST_HALT;
          end else begin
            state_next   = ST_CLEAR;
            kind_next    = ATT_FALLBACK;
            wdt_off_next = 1'b1;
          end
        end else if (internal_reprogram_cmd &&
                     kind_reg != ATT_FALLBACK) begin
          push_c        = 1'b1;
          state_next    = ST_CLEAR;
          kind_next     = ATT_REPROG;
          start_ws_next = warm_reg;
        end else if (load_evt.startup_done) begin
          push_c     = 1'b1;
          state_next = ST_USER;
        end
      end
      ST_USER: begin
        if (internal_reprogram_cmd) begin
          state_next    = ST_CLEAR;
          kind_next     = ATT_REPROG;
          start_ws_next = warm_reg;
          wdt_off_next  = 1'b0;
        end
      end
      default: begin
        state_next = ST_HALT;
      end
    endcase
    if (state_next == ST_CLEAR && state_reg != ST_CLEAR) begin
      clr_cnt_next = '0;
      reprog_next  = (kind_next == ATT_REPROG);
    end
    if (push_c) begin
      hist1_next = hist0_reg;
      hist0_next = ent;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg    <= ST_CLEAR;
      kind_reg     <= ATT_POWERUP;
      clr_cnt_reg  <= '0;
      start_ws_reg <= WARM_START_RST;
      reprog_reg   <= 1'b0;
      wdt_off_reg  <= 1'b0;
      hist0_reg    <= HIST_RST;
      hist1_reg    <= HIST_RST;
    end else begin
      state_reg    <= state_next;
      kind_reg     <= kind_next;
      clr_cnt_reg  <= clr_cnt_next;
      start_ws_reg <= start_ws_next;
      reprog_reg   <= reprog_next;
      wdt_off_reg  <= wdt_off_next;
      hist0_reg    <= hist0_next;
      hist1_reg    <= hist1_next;
    end
  end

  // ==========================================================
  // pins toward flash and board; built from next state so they
  // line up with the state register
  always_comb begin
    init_n_next = (state_next == ST_LOAD || state_next == ST_USER);
    done_next   = (state_next == ST_USER);
    rs_oe_next  = 2'b00;
    rs_out_next = 2'b00;
    addr_next   = '0;
    if (state_next == ST_CLEAR || state_next == ST_LOAD) begin
      if (kind_next == ATT_FALLBACK) begin
        if (mode == MODE_PARALLEL_FLASH || mode == MODE_PARALLEL_PORT) begin
          rs_oe_next  = RS_DRIVE_ALL;
          rs_out_next = RS_FALLBACK;
        end
      end else if (kind_next == ATT_REPROG) begin
        if (mode != MODE_SERIAL_FLASH) begin
          rs_oe_next  = RS_DRIVE_ALL;
          rs_out_next = start_ws_next[WS_RS_LSB +: 2];
        end
        if (mode == MODE_PARALLEL_FLASH) begin
          addr_next = {3'b000, start_ws_next[WS_ADDR_W-1:0]};
        end else if (mode == MODE_SERIAL_FLASH) begin
          // images there must open with 256 dummy bytes
          addr_next = {start_ws_next[WS_SPI_W-1:0], SPI_LOW_BYTE};
        end
      end
    end
  end

  // ==========================================================
  // readback of registers; unmapped indices answer zero
  always_comb begin
    rdd_next = rdd_reg;
    if (rd_req) begin
      if (rd_addr == REG_BOOT_HIST) begin
        rdd_next = bit_swap({16'h0000, hist1_reg, hist0_reg});
      end else if (rd_addr == REG_WARM_START) begin
        rdd_next = bit_swap(warm_reg);
      end else if (rd_addr == REG_TIMER) begin
        rdd_next = bit_swap(timer_reg);
      end else begin
        rdd_next = '0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      init_n_reg <= 1'b0;
      done_reg   <= 1'b0;
      rs_oe_reg  <= 2'b00;
      rs_out_reg <= 2'b00;
      addr_reg   <= '0;
      ldst_reg   <= 1'b0;
      rdv_reg    <= 1'b0;
      rdd_reg    <= '0;
    end else begin
      init_n_reg <= init_n_next;
      done_reg   <= done_next;
      rs_oe_reg  <= rs_oe_next;
      rs_out_reg <= rs_out_next;
      addr_reg   <= addr_next;
      ldst_reg   <= load_start_c;
      rdv_reg    <= rd_req;
      rdd_reg    <= rdd_next;
    end
  end

  assign init_n     = init_n_reg;
  assign done       = done_reg;
  assign rs_oe      = rs_oe_reg;
  assign rs_out     = rs_out_reg;
  assign load_addr  = addr_reg;
  assign load_start = ldst_reg;
  assign rd_valid   = rdv_reg;
  assign rd_data    = rdd_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence held_in_reset_s;
    (!init_n && !done) [*2];
  endsequence

  sequence init_release_s;
    ##[1:200] init_n;
  endsequence

  mon_exclusive_a: assert property (
    !(timer_reg[TMR_CFG_MON] && timer_reg[TMR_USR_MON]))
    else $error("both watchdog modes active");

  wdt_reload_a: assert property (
    load_start_c |=> wdt_reg == $past(tmr_val))
    else $error("watchdog not loaded from timer at load start");

  wdt_expiry_a: assert property (
    wdt_fire |=> state_reg == ST_CLEAR && kind_reg == ATT_FALLBACK)
    else $error("watchdog expiry did not start fallback");

  rs_idle_a: assert property (
    state_reg == ST_USER |-> rs_oe == 2'b00)
    else $error("revision select driven while running");

  rs_fallback_a: assert property (
    (kind_reg == ATT_FALLBACK && state_reg == ST_LOAD)
    |-> (mode == MODE_SERIAL_FLASH) ? rs_oe == 2'b00
                                     : (rs_oe == 2'b11 || mode == MODE_OTHER)
                                       && rs_out == 2'b00)
    else $error("revision select wrong during fallback");

  fallback_addr_a: assert property (
    (load_start && kind_reg == ATT_FALLBACK) |-> load_addr == '0)
    else $error("fallback not started at address zero");

  reprog_restart_a: assert property (
    (state_reg == ST_USER && internal_reprogram_cmd)
    |=> held_in_reset_s ##0 init_release_s ##0 load_start)
    else $error("reprogram did not clear then load");

  hist_shift_a: assert property (
    push_c |=> hist1_reg == $past(hist0_reg) && hist0_reg.valid)
    else $error("history did not shift");

  fb_entry_a: assert property (
    (push_c && kind_reg == ATT_FALLBACK && state_next == ST_USER)
    |=> hist0_reg.fallback && hist1_reg == $past(hist0_reg))
    else $error("fallback entry wrong");

  fb_ignore_a: assert property (
    (state_reg == ST_LOAD && kind_reg == ATT_FALLBACK &&
     internal_reprogram_cmd &&
     !load_evt.startup_done && !push_c) |=> state_reg == ST_LOAD)
    else $error("reprogram obeyed during fallback");

  halt_a: assert property (
    state_reg == ST_HALT |=> state_reg == ST_HALT && !init_n && !done)
    else $error("failed fallback did not halt");

  warm_clear_a: assert property (
    load_start_c |=> warm_reg == WARM_START_RST)
    else $error("warm start not cleared at load start");

  null_cmd_a: assert property (
    (state_reg == ST_USER && wr.valid && wr.addr == REG_CMD &&
     wr.data == '0) |=> state_reg == ST_USER)
    else $error("null command changed state");

endmodule : multiboot_fallback_reconfig

//--- hdl/boot_ctrl_pkg.sv
package boot_ctrl_pkg;

  // ==========================================================
  // packet framing
  localparam logic [31:0] SYNC_WORD    = 32'haa99_5566;
  localparam int          HDR_TYPE_LSB = 29;
  localparam int          HDR_OP_LSB   = 27;
  localparam int          HDR_ADDR_LSB = 13;
  localparam int          HDR_CNT_W    = 11;
  localparam int          REG_ADDR_W   = 5;
  localparam logic [2:0]  HDR_TYPE1    = 3'h1;
  localparam logic [1:0]  OP_READ      = 2'h1;
  localparam logic [1:0]  OP_WRITE     = 2'h2;

  // ==========================================================
  // register indices
  localparam logic [4:0]  REG_CMD        = 5'h04;
  localparam logic [4:0]  REG_WARM_START = 5'h10;
  localparam logic [4:0]  REG_TIMER      = 5'h11;
  localparam logic [4:0]  REG_BOOT_HIST  = 5'h16;

  // ==========================================================
  // command codes and field layouts
  localparam logic [3:0]  CMD_REPROG_BITS = 4'hf;
  localparam logic [31:0] CMD_DESYNC      = 32'h0000_000d;
  localparam int          WS_RS_LSB       = 30;
  localparam int          WS_ADDR_W       = 29;
  localparam int          WS_SPI_W        = 24;
  localparam logic [7:0]  SPI_LOW_BYTE    = 8'h00;
  localparam logic [1:0]  RS_FALLBACK     = 2'h0;
  localparam logic [1:0]  RS_DRIVE_ALL    = 2'h3;
  localparam int          TMR_VAL_W       = 30;
  localparam int          TMR_CFG_MON     = 30;
  localparam int          TMR_USR_MON     = 31;
  localparam logic [31:0] WARM_START_RST  = 32'h0000_0000;
  localparam logic [31:0] TIMER_RST       = 32'h0000_0000;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int WDT_SRC_MHZ   = 65;
  localparam int WDT_PREDIV    = 256;
  localparam int WDT_TICK_CYC  =
    (WDT_PREDIV * 1000) / (WDT_SRC_MHZ * CLK_PERIOD_NS);
  localparam int CLEAR_CYC_DEF = 64;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    MODE_SERIAL_FLASH, MODE_PARALLEL_FLASH, MODE_PARALLEL_PORT, MODE_OTHER
  } cfg_mode_type;

  typedef enum logic [1:0] {
    ATT_POWERUP, ATT_REPROG, ATT_FALLBACK
  } attempt_type;

  typedef enum logic [1:0] {
    ST_CLEAR, ST_LOAD, ST_USER, ST_HALT
  } load_state_type;

  // msb to lsb layout of one history entry
  typedef struct packed {
    logic reserved;
    logic wrap_err;
    logic crc_err;
    logic device_code_mismatch_flag;
    logic watchdog_expiry_flag;
    logic reprog;
    logic fallback;
    logic valid;
  } hist_entry_type;

  localparam hist_entry_type HIST_RST = '0;

  typedef struct packed {
    logic        valid;
    logic [4:0]  addr;
    logic [31:0] data;
  } reg_wr_type;

  typedef struct packed {
    logic crc_err;
    logic id_err;
    logic wrap_err;
    logic startup_done;
  } load_evt_type;

  // bits reversed inside every byte, as on the parallel port
  function automatic logic [31:0] bit_swap(input logic [31:0] w);
    logic [31:0] r;
    r = '0;
    for (int b = 0; b < 4; b++) begin
      for (int i = 0; i < 8; i++) begin
        r[8*b+i] = w[8*b+7-i];
      end
    end
    return r;
  endfunction : bit_swap

endpackage : boot_ctrl_pkg

//--- hdl/cfg_packet_decoder.sv
`timescale 1ns/1ps

module cfg_packet_decoder
  import boot_ctrl_pkg::*;
(
  input  logic        ref_clk,
  input  logic        nrst,
  input  logic        abort,
  input  logic        word_valid,
  input  logic [31:0] word_data,
  output reg_wr_type  wr,
  output logic        rd_req,
  output logic [4:0]  rd_addr
);

  logic                 synced_reg, synced_next;
  logic [HDR_CNT_W-1:0] cnt_reg,    cnt_next;
  logic [1:0]           op_reg,     op_next;
  logic [4:0]           addr_reg,   addr_next;
  reg_wr_type           wr_reg,     wr_next;
  logic                 rd_reg,     rd_next;
  logic [4:0]           rda_reg,    rda_next;
  logic [31:0]          w;

  assign w = bit_swap(word_data);

  // ==========================================================
  // sync, header and payload tracking
  always_comb begin
    synced_next = synced_reg;
    cnt_next    = cnt_reg;
    op_next     = op_reg;
    addr_next   = addr_reg;
    wr_next     = '0;
    rd_next     = 1'b0;
    rda_next    = rda_reg;
    if (abort) begin
      synced_next = 1'b0;
      cnt_next    = '0;
    end else if (word_valid) begin
      if (!synced_reg) begin
        synced_next = (w == SYNC_WORD);
      end else if (cnt_reg != '0) begin
        cnt_next = cnt_reg - 11'd1;
        if (op_reg == OP_WRITE) begin
          wr_next.valid = 1'b1;
          wr_next.addr  = addr_reg;
          wr_next.data  = w;
          if (addr_reg == REG_CMD && w == CMD_DESYNC) begin
            synced_next = 1'b0;
          end
        end
      end else if (w[HDR_TYPE_LSB +: 3] == HDR_TYPE1) begin
        op_next   = w[HDR_OP_LSB +: 2];
        addr_next = w[HDR_ADDR_LSB +: REG_ADDR_W];
        if (w[HDR_OP_LSB +: 2] == OP_READ) begin
          // reads answer one word and consume no payload
          rd_next  = 1'b1;
          rda_next = w[HDR_ADDR_LSB +: REG_ADDR_W];
        end else begin
          cnt_next = w[HDR_CNT_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      synced_reg <= 1'b0;
      cnt_reg    <= '0;
      op_reg     <= '0;
      addr_reg   <= '0;
      wr_reg     <= '0;
      rd_reg     <= 1'b0;
      rda_reg    <= '0;
    end else begin
      synced_reg <= synced_next;
      cnt_reg    <= cnt_next;
      op_reg     <= op_next;
      addr_reg   <= addr_next;
      wr_reg     <= wr_next;
      rd_reg     <= rd_next;
      rda_reg    <= rda_next;
    end
  end

  assign wr      = wr_reg;
  assign rd_req  = rd_reg;
  assign rd_addr = rda_reg;

endmodule : cfg_packet_decoder

//--- bench/boot_flash_model.sv
`timescale 1ns/1ps

// ====
// flash feeding one short image per load request
module boot_flash_model #(
  parameter logic [31:0] WS = 32'h0000_0000
) (
  input  logic        ref_clk,
  input  logic        load_start,
  output logic        flash_valid,
  output logic [31:0] flash_data
);
  int idx = 7;
  logic [31:0] img [7] = '{32'haa99_5566, 32'h3002_2001,
    32'h4000_ffff, 32'h3002_0001, WS, 32'h3000_8001,
    32'h0000_000d};
  initial flash_valid = 0;
  initial flash_data = 0;
  function automatic logic [31:0] sw(logic [31:0] w);
    for (int i = 0; i < 32; i++) sw[i] = w[i^7];
  endfunction : sw
  always @(posedge ref_clk) if (load_start) idx <= 0;
  // idle data toggles so a stale word is never mistaken for a fresh one
  always @(negedge ref_clk) begin
    flash_valid <= idx < 7;
    flash_data <= idx < 7 ? sw(img[idx%7]) : ~flash_data;
    if (idx < 7) idx <= idx + 1;
  end
endmodule : boot_flash_model

//--- bench/multiboot_fallback_reconfig_tb_top.sv
`timescale 1ns/1ps

module multiboot_fallback_reconfig_tb_top;
  import boot_ctrl_pkg::*;
  localparam logic [31:0] WS1 = 32'hc000_1000;
  localparam logic [31:0] WS2 = 32'h8000_2000;
  logic ref_clk = 0, nrst = 0, icp_valid = 0, flash_valid;
  logic [31:0] icp_data = 0, flash_data, rd_data, load_addr, got;
  logic [1:0] mode_pins = 2'h1, rs_out, rs_oe;
  load_evt_type load_evt = '0;
  logic rd_valid, load_start, init_n, done;
  int errors = 0, compares = 0;

  always #20 ref_clk = ~ref_clk;

  multiboot_fallback_reconfig #(.CLEAR_CYCLES(4), .TICK_CYCLES(2))
    u_multiboot_fallback_reconfig (.ref_clk(ref_clk), .nrst(nrst),
    .mode_pins(mode_pins), .icp_valid(icp_valid), .icp_data(icp_data),
    .flash_valid(flash_valid), .flash_data(flash_data),
    .load_evt(load_evt), .rd_valid(rd_valid), .rd_data(rd_data),
    .load_start(load_start), .load_addr(load_addr), .rs_out(rs_out),
    .rs_oe(rs_oe), .init_n(init_n), .done(done));
  boot_flash_model #(.WS(WS1)) u_boot_flash_model (.ref_clk(ref_clk),
    .load_start(load_start), .flash_valid(flash_valid),
    .flash_data(flash_data));

  // ====
  // helpers
  function automatic logic [31:0] sw(logic [31:0] w);
    for (int i = 0; i < 32; i++) sw[i] = w[i^7];
  endfunction : sw
  task automatic end_of_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic icp(logic [31:0] w);
    @(negedge ref_clk);
    icp_valid = 1;
    icp_data = sw(w);
    @(negedge ref_clk);
    icp_valid = 0;
  endtask : icp
  task automatic rd(logic [31:0] hdr, output logic [31:0] v);
    int n;
    n = 0;
    icp(SYNC_WORD);
    icp(hdr);
    while (rd_valid !== 1'b1 && n < 4) begin
      @(negedge ref_clk);
      n++;
    end
    if (rd_valid !== 1'b1) begin
      errors++;
      end_of_test();
    end
    v = sw(rd_data);
    icp(32'h3000_8001);
    icp(CMD_DESYNC);
  endtask : rd
  task automatic wait_start;
    int n;
    n = 0;
    while (load_start !== 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    if (load_start !== 1'b1) begin
      errors++;
      end_of_test();
    end
  endtask : wait_start
  task automatic reprog(logic [31:0] ws);
    icp(SYNC_WORD);
    icp(32'h3002_0001);
    icp(ws);
    icp(32'h3000_8001);
    icp(32'h0000_000f);
  endtask : reprog
  // events wait until the image words have streamed in
  task automatic evt(logic [3:0] e);
    repeat (12) @(negedge ref_clk);
    load_evt = load_evt_type'(e);
    @(negedge ref_clk);
    load_evt = '0;
    @(negedge ref_clk);
  endtask : evt

  // ====
  // main sequence
  initial begin
    repeat (8) @(negedge ref_clk);
    chk("rs_oe", 0, rs_oe);
    nrst = 1;
    wait_start;
    chk("init_n", 1, init_n);
    chk("load_addr", 0, load_addr);
    evt(4'h1);
    chk("done", 1, done);
    rd(32'h2802_c001, got);
    chk("history", 32'h0000_0001, got);
    rd(32'h2802_0001, got);
    chk("warm_start", WS1, got);
    icp(SYNC_WORD);
    icp(32'h3000_8001);
    icp(32'h0);
    icp(32'h3000_8001);
    icp(CMD_DESYNC);
    repeat (3) @(negedge ref_clk);
    chk("done", 1, done);
    reprog(WS2);
    repeat (2) @(negedge ref_clk);
    chk("init_n", 0, init_n);
    chk("done", 0, done);
    chk("rs_oe", 3, rs_oe);
    chk("rs_out", WS2[31:30], rs_out);
    wait_start;
    chk("load_addr", {3'h0, WS2[28:0]}, load_addr);
    evt(4'h8);
    wait_start;
    chk("load_addr", 0, load_addr);
    chk("rs_out", 0, rs_out);
    chk("rs_oe", 3, rs_oe);
    evt(4'h1);
    rd(32'h2802_c001, got);
    chk("history", 32'h0000_2503, got);
    mode_pins = 2'h0;
    repeat (4) @(negedge ref_clk);
    reprog(WS2);
    repeat (2) @(negedge ref_clk);
    chk("rs_oe", 0, rs_oe);
    wait_start;
    chk("load_addr", {WS2[23:0], 8'h00}, load_addr);
    evt(4'h8);
    wait_start;
    chk("rs_oe", 0, rs_oe);
    evt(4'h8);
    chk("init_n", 0, init_n);
    chk("done", 0, done);
    end_of_test();
  end
endmodule : multiboot_fallback_reconfig_tb_top
